// [sim/dbt_cpu_model.sv]
// processor bus model with the capture data it expects
`timescale 1ns/100ps
`default_nettype none
module dbt_cpu_model (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// bench control
	input  wire logic        en,
	input  wire logic        seq,
	input  wire logic [15:0] ca,
	input  wire logic [15:0] cb,
	// processor bus
	output logic             bus_valid,
	output logic      [15:0] bus_addr,
	output logic      [7:0]  bus_data,
	output logic             bus_rw,
	// run state of the block
	input  wire logic        run_active
);
	integer      seed = 1;
	logic        seen;
	logic [2:0]  pick;
	logic [31:0] r;
	logic [7:0]  cap[$];
	// one random cycle per clock unless pick is 7, noise on the lines while idle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_valid <= 1'b0;
			bus_addr <= 16'h0;
			bus_data <= 8'h0;
			bus_rw <= 1'b0;
			seen <= 1'b0;
		end else begin
			if (bus_valid && run_active && bus_addr == cb && (!seq || seen) && cap.size() < 8)
				cap.push_back(bus_data);
			seen <= en && run_active && (seen || bus_valid && bus_addr == ca);
			pick = 3'($random(seed));
			r = $random(seed);
			bus_valid <= en && pick != 3'h7;
			bus_addr <= pick == 0 ? ca : pick == 1 ? cb : pick == 2 ? ca - 16'h1 :
				pick == 3 ? cb + 16'h1 : ca + 16'(pick);
			bus_data <= r[8] ? cb[7:0] : r[7:0];
			bus_rw <= r[9];
		end
	end
endmodule
`default_nettype wire

// [sim/dbt_trigger_assertions.sv]
// port checker for the debug trigger comparator
`timescale 1ns/100ps
`default_nettype none
module dbt_trigger_chk (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// register bus
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// observed bus and core outputs
	input wire logic        bus_valid,
	input wire logic [15:0] bus_addr,
	input wire logic [7:0]  bus_data,
	input wire logic        bus_rw,
	input wire logic        trigger_pulse,
	input wire logic        break_request,
	input wire logic        break_is_tag,
	input wire logic        run_active
);
	logic [15:0] ca_q;
	logic [15:0] cb_q;
	logic [8:0]  ctl_q;
	logic        seen_q;
	logic        wr;
	logic        ea;
	logic        eb;
	logic        dok;
	logic [3:0]  md;
	// decoded shadow state
	assign wr  = psel & penable & pready & pwrite & ~pslverr;
	assign md  = ctl_q[4:1];
	assign ea  = bus_addr == ca_q;
	assign eb  = bus_addr == cb_q;
	assign dok = !ctl_q[5] || bus_rw == ctl_q[6];
	// shadow of comparator and control writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ca_q  <= 16'h0000;
			cb_q  <= 16'h0000;
			ctl_q <= 9'h000;
		end else if (wr) begin
			if (paddr == 8'h00) ca_q <= pwdata[15:0];
			if (paddr == 8'h04) cb_q <= pwdata[15:0];
			if (paddr == 8'h08) ctl_q <= pwdata[8:0];
		end
	end
	// remembered comparator a hit, dropped by every control write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) seen_q <= 1'b0;
		else if (wr && paddr == 8'h08) seen_q <= 1'b0;
		else if (run_active && bus_valid && md == 4'h2 && ea) seen_q <= 1'b1;
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// one observed cycle during a run
	sequence s_go;
		run_active && bus_valid;
	endsequence
	property p_hit;
		s_go ##0 (md == 4'h0 && ea || md == 4'h1 && (ea || eb)) |=> trigger_pulse;
	endproperty
	a_hit: assert property (p_hit) else $error("address hit missed");
	property p_seq;
		s_go ##0 (md == 4'h2 && seen_q && eb) |=> trigger_pulse;
	endproperty
	a_seq: assert property (p_seq) else $error("b after a missed");
	property p_cold;
		s_go ##0 (md == 4'h2 && !seen_q) |=> !trigger_pulse;
	endproperty
	a_cold: assert property (p_cold) else $error("b without a fired");
	property p_full;
		s_go ##0 (md == 4'h3 && ea && bus_data == cb_q[7:0] && dok) |=> trigger_pulse;
	endproperty
	a_full: assert property (p_full) else $error("full match missed");
	property p_nodata;
		s_go ##0 (md == 4'h4 && ea && bus_data != cb_q[7:0] && dok) |=> trigger_pulse;
	endproperty
	a_nodata: assert property (p_nodata) else $error("data miss missed");
	property p_tag;
		s_go ##0 ((md == 4'h3 || md == 4'h4) && ctl_q[8:7] == 2'b11 && ea)
			|=> break_request && break_is_tag;
	endproperty
	a_tag: assert property (p_tag) else $error("tag break missed");
	property p_in;
		s_go ##0 (md == 4'h7 && bus_addr >= ca_q && bus_addr <= cb_q) |=> trigger_pulse;
	endproperty
	a_in: assert property (p_in) else $error("inside range missed");
	property p_out;
		s_go ##0 (md == 4'h8 && (bus_addr < ca_q || bus_addr > cb_q)) |=> trigger_pulse;
	endproperty
	a_out: assert property (p_out) else $error("outside range missed");
	property p_miss;
		s_go ##0 (md == 4'h0 && !ea) |=> !trigger_pulse;
	endproperty
	a_miss: assert property (p_miss) else $error("a-only fired without match");
	property p_evt;
		s_go ##0 (md == 4'h5 && eb) |=> trigger_pulse;
	endproperty
	a_evt: assert property (p_evt) else $error("event b missed");
	property p_brk;
		s_go ##0 (ctl_q[7] && !(ctl_q[8] && (md == 4'h3 || md == 4'h4)))
			|=> break_request == trigger_pulse;
	endproperty
	a_brk: assert property (p_brk) else $error("break not with trigger");
	property p_nobrk;
		s_go ##0 !ctl_q[7] |=> !break_request;
	endproperty
	a_nobrk: assert property (p_nobrk) else $error("break while disabled");
endmodule
bind dbt_trigger dbt_trigger_chk u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
	.bus_valid(bus_valid), .bus_addr(bus_addr), .bus_data(bus_data), .bus_rw(bus_rw),
	.trigger_pulse(trigger_pulse), .break_request(break_request),
	.break_is_tag(break_is_tag), .run_active(run_active)
);
`default_nettype wire

// [sim/debug_trigger_comparator_test.sv]
// self-checking bench for the debug trigger comparator
`timescale 1ns/100ps
`default_nettype none
module debug_trigger_comparator_test;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er, en, seq;
	logic        bus_valid, bus_rw, trigger_pulse, break_request, break_is_tag, run_active;
	logic [7:0]  paddr, bus_data;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] ca, cb, bus_addr, tca;
	logic [3:0]  d;
	integer      err_count = 0, tests_run = 0, seed = 1, m, i, k, n;
	dbt_trigger u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.bus_valid(bus_valid), .bus_addr(bus_addr), .bus_data(bus_data), .bus_rw(bus_rw),
		.trigger_pulse(trigger_pulse), .break_request(break_request),
		.break_is_tag(break_is_tag), .run_active(run_active)
	);
	dbt_cpu_model u_cpu (
		.pclk(pclk), .presetn(presetn), .en(en), .seq(seq), .ca(ca), .cb(cb),
		.bus_valid(bus_valid), .bus_addr(bus_addr), .bus_data(bus_data), .bus_rw(bus_rw),
		.run_active(run_active)
	);
	// expected control word: arm, mode, direction bits, random break and tag (forced in full modes)
	function automatic logic [31:0] ctl(input integer m, input logic [3:0] d);
		ctl = {23'h0, d[3] || m == 3 || m == 4, d[2] || m == 3 || m == 4, d[1:0], 4'(m), 1'b1};
	endfunction
	// expected status with trigger and a-seen bits masked
	function automatic logic [31:0] stat_exp(input integer n);
		stat_exp = {24'h0, 4'(n), n == 8, 2'b00, n < 8};
	endfunction
	// one register bus transfer, held until pready
	task apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task stop_test;
		$display("checks=%0d errors=%0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// watchdog
	initial begin
		#100000;
		err_count++;
		stop_test;
	end
	// main sequence
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		en = 1'b0;
		seq = 1'b0;
		ca = 16'h0;
		cb = 16'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		// reset values, empty fifo read and an unmapped place
		for (i = 0; i < 6; i++) begin
			apb(1'b0, 8'(i * 4), 32'h0, rd, er);
			chk(rd, 32'h0);
			chk(32'(er), 32'(i == 5));
		end
		// every trigger mode, three armed runs each
		for (m = 0; m < 9; m++) begin
			tca = 16'h1000 + 16'($random(seed) & 32'h0ff0);
			ca <= tca;
			cb <= tca + 16'h8;
			seq <= m == 6;
			apb(1'b1, 8'h00, {16'h0, tca}, rd, er);
			apb(1'b1, 8'h04, {16'h0, tca + 16'h8}, rd, er);
			for (k = 0; k < 3; k++) begin
				u_cpu.cap.delete();
				d = 4'($random(seed));
				apb(1'b1, 8'h08, ctl(m, d), rd, er);
				en <= 1'b1;
				repeat (40) @(posedge pclk);
				en <= 1'b0;
				repeat (2) @(posedge pclk);
			end
			apb(1'b0, 8'h0c, 32'h0, rd, er);
			if (m == 5 || m == 6) begin
				n = u_cpu.cap.size();
				chk(rd & 32'hf9, stat_exp(n));
				for (i = 0; i < n; i++) begin
					apb(1'b0, 8'h10, 32'h0, rd, er);
					chk(rd, {24'h0, u_cpu.cap[i]});
				end
			end
			apb(1'b1, 8'h08, 32'h0, rd, er);
		end
		stop_test;
	end
endmodule
`default_nettype wire

// [verilog/dbt_cmp.sv]
// address and data comparators against the two comparator values
`timescale 1ns/100ps
`default_nettype none
`include "dbt_regs.svh"

module dbt_cmp (
	// observed bus
	input  wire logic [`DBT_ADDR_W-1:0] addr,
	input  wire logic [`DBT_DATA_W-1:0] data,
	// comparator values
	input  wire logic [`DBT_ADDR_W-1:0] cmp_a,
	input  wire logic [`DBT_ADDR_W-1:0] cmp_b,
	// results
	output logic                        eq_a,
	output logic                        eq_b,
	output logic                        ge_a,
	output logic                        le_b,
	output logic                        data_eq
);

	// address equality and range bounds
	assign eq_a = (addr == cmp_a);
	assign eq_b = (addr == cmp_b);
	assign ge_a = (addr >= cmp_a);
	assign le_b = (addr <= cmp_b);

	// data is checked against the low byte of comparator b only
	assign data_eq = (data == cmp_b[`DBT_DATA_W-1:0]);

endmodule
`default_nettype wire

// [verilog/dbt_fifo_mem.sv]
// capture memory for the debug trigger fifo, registered read data
`timescale 1ns/100ps
`default_nettype none
`include "dbt_regs.svh"

module dbt_fifo_mem (
	// clock
	input  wire logic                   pclk,
	// write port
	input  wire logic                   wr_en,
	input  wire logic [`DBT_PTR_W-1:0]  wr_addr,
	input  wire logic [`DBT_DATA_W-1:0] wr_data,
	// read port
	input  wire logic [`DBT_PTR_W-1:0]  rd_addr,
	output logic      [`DBT_DATA_W-1:0] rd_data
);

	logic [`DBT_DATA_W-1:0] mem [`DBT_FIFO_DEPTH];

	// storage write
	always_ff @(posedge pclk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// registered read of the head entry
	always_ff @(posedge pclk) begin
		rd_data <= mem[rd_addr];
	end

endmodule
`default_nettype wire

// [verilog/dbt_pkg.sv]
// types shared by the debug trigger block
`default_nettype none
package dbt_pkg;

	// trigger modes in control field order; codes above the last are illegal
	typedef enum logic [3:0] {
		DBT_A_ONLY,
		DBT_A_OR_B,
		DBT_A_THEN_B,
		DBT_A_AND_DATA,
		DBT_A_AND_NOT_DATA,
		DBT_EVENT_B,
		DBT_A_THEN_EVENT_B,
		DBT_INSIDE,
		DBT_OUTSIDE
	} dbt_mode_t;

endpackage
`default_nettype wire

// [verilog/dbt_regs.svh]
// register map, field positions, reset values and sizes of the debug trigger block
`ifndef DBT_REGS_SVH
`define DBT_REGS_SVH

// sizes
`define DBT_ADDR_W      16
`define DBT_DATA_W      8
`define DBT_FIFO_DEPTH  8
`define DBT_PTR_W       3
`define DBT_CNT_W       4
`define DBT_PADDR_W     8

// register byte offsets
`define DBT_OFF_CMPA    8'h00
`define DBT_OFF_CMPB    8'h04
`define DBT_OFF_CTRL    8'h08
`define DBT_OFF_STAT    8'h0c
`define DBT_OFF_FIFO    8'h10

// control fields
`define DBT_CTRL_W      9
`define DBT_CTRL_ARM    0
`define DBT_CTRL_MD_LO  1
`define DBT_CTRL_MD_HI  4
`define DBT_CTRL_DIREN  5
`define DBT_CTRL_DIRVAL 6
`define DBT_CTRL_PROCESSOR_BREAK_ENABLE  7
`define DBT_CTRL_TAG    8

// status fields
`define DBT_STAT_RUN    0
`define DBT_STAT_AHIT   1
`define DBT_STAT_TRIG   2
`define DBT_STAT_FULL   3
`define DBT_STAT_CN_LO  4
`define DBT_STAT_CN_HI  7

// reset values and full count
`define DBT_CMP_RST     16'h0000
`define DBT_CTRL_RST    9'h000
`define DBT_CNT_FULL    4'h8

`endif

// [verilog/dbt_trigger.sv]
// debug trigger comparator with capture fifo and apb register slave
`timescale 1ns/100ps
`default_nettype none
`include "dbt_regs.svh"

// Overview of operation
// [RULE1] A-only mode triggers whenever bus address equals comparator A.
// [RULE2] Either mode triggers when address equals comparator A or comparator B.
// [RULE3] A-then-B triggers on B match after an earlier A match, any gap.
// [RULE4] Full data mode: A address, B low byte data, optional direction match.
// [RULE5] Tag breakpoint in full modes ignores data; breaks on A address match.
// [RULE6] Full not-data mode: A address, data mismatch, optional direction match.
// [RULE7] Event-only B captures data of every cycle matching comparator B.
// [RULE8] Data-storing modes end the debug run once the fifo is full.
// [RULE9] After an A match, every B match captures that cycle's data.
// [RULE10] Inside range triggers when A <= address <= B.
// [RULE11] Outside range triggers when address < A or address > B.
// [RULE12] Arming a new run clears the remembered A match.
module dbt_trigger (
	// clock and reset
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	// apb slave
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [`DBT_PADDR_W-1:0] paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	// observed processor bus, one qualified cycle per bus_valid
	input  wire logic                   bus_valid,
	input  wire logic [`DBT_ADDR_W-1:0] bus_addr,
	input  wire logic [`DBT_DATA_W-1:0] bus_data,
	input  wire logic                   bus_rw,
	// to the processor core
	output logic                        trigger_pulse,
	output logic                        break_request,
	output logic                        break_is_tag,
	output logic                        run_active
);

	// register state
	logic [`DBT_ADDR_W-1:0] cmpa_q;
	logic [`DBT_ADDR_W-1:0] cmpb_q;
	logic [`DBT_CTRL_W-1:0] ctrl_q;
	logic                   run_q;
	logic                   a_seen_q;
	logic                   trig_seen_q;
	logic                   acc_done_q;
	logic                   head_stale_q;
	logic [31:0]            rdata_q;
	logic                   pop_ok_q;
	logic                   trig_q;
	logic                   brk_q;
	logic                   tag_q;

	// fifo state
	logic [`DBT_PTR_W-1:0]  wr_ptr_q;
	logic [`DBT_PTR_W-1:0]  rd_ptr_q;
	logic [`DBT_CNT_W-1:0]  cnt_q;
	logic [`DBT_DATA_W-1:0] head_data;

	// comparator results
	logic eq_a;
	logic eq_b;
	logic ge_a;
	logic le_b;
	logic data_eq;

	// decoded control
	dbt_pkg::dbt_mode_t mode;
	logic               dir_ok;
	logic               watch;
	logic               hit;
	logic               store_mode;
	logic               full_mode;
	logic               seq_mode;
	logic               fifo_full;
	logic               push;
	logic               pop;
	logic               brk_now;

	// apb decode
	logic               access;
	logic               done;
	logic               wr_cmpa;
	logic               wr_cmpb;
	logic               wr_ctrl;
	logic               arm;
	logic               mapped;
	logic [31:0]        rd_mux;

	// true when the byte address selects the given register
	function automatic logic sel_reg(input logic [`DBT_PADDR_W-1:0] a,
	                                 input logic [`DBT_PADDR_W-1:0] off);
		sel_reg = (a == off);
	endfunction

	dbt_cmp u_cmp (
		.addr    (bus_addr),
		.data    (bus_data),
		.cmp_a   (cmpa_q),
		.cmp_b   (cmpb_q),
		.eq_a    (eq_a),
		.eq_b    (eq_b),
		.ge_a    (ge_a),
		.le_b    (le_b),
		.data_eq (data_eq)
	);

	dbt_fifo_mem u_mem (
		.pclk    (pclk),
		.wr_en   (push),
		.wr_addr (wr_ptr_q),
		.wr_data (bus_data),
		.rd_addr (rd_ptr_q),
		.rd_data (head_data)
	);

	// control field decode
	assign mode       = dbt_pkg::dbt_mode_t'(ctrl_q[`DBT_CTRL_MD_HI:`DBT_CTRL_MD_LO]);
	assign dir_ok     = ~ctrl_q[`DBT_CTRL_DIREN] | (bus_rw == ctrl_q[`DBT_CTRL_DIRVAL]);
	assign watch      = bus_valid & run_q;
	assign store_mode = (mode == dbt_pkg::DBT_EVENT_B) | (mode == dbt_pkg::DBT_A_THEN_EVENT_B);
	assign full_mode  = (mode == dbt_pkg::DBT_A_AND_DATA) | (mode == dbt_pkg::DBT_A_AND_NOT_DATA);
	assign seq_mode   = (mode == dbt_pkg::DBT_A_THEN_B) | (mode == dbt_pkg::DBT_A_THEN_EVENT_B);
	assign fifo_full  = (cnt_q == `DBT_CNT_FULL);

	// trigger condition of the selected mode for the current bus cycle
	always_comb begin
		hit = 1'b0;
		unique case (mode)
			dbt_pkg::DBT_A_ONLY:         hit = eq_a;                     // [RULE1]
			dbt_pkg::DBT_A_OR_B:         hit = eq_a | eq_b;              // [RULE2]
			dbt_pkg::DBT_A_THEN_B:       hit = eq_b & a_seen_q;          // [RULE3]
			dbt_pkg::DBT_A_AND_DATA:     hit = eq_a & data_eq & dir_ok;  // [RULE4]
			dbt_pkg::DBT_A_AND_NOT_DATA: hit = eq_a & ~data_eq & dir_ok; // [RULE6]
			dbt_pkg::DBT_EVENT_B:        hit = eq_b;                     // [RULE7]
			dbt_pkg::DBT_A_THEN_EVENT_B: hit = eq_b & a_seen_q;          // [RULE9]
			dbt_pkg::DBT_INSIDE:         hit = ge_a & le_b;              // [RULE10]
			dbt_pkg::DBT_OUTSIDE:        hit = ~ge_a | ~le_b;            // [RULE11]
			default:                     hit = 1'b0;
		endcase
		hit = hit & watch;
	end

	// store-mode events write the cycle's data while room remains
	assign push = hit & store_mode & ~fifo_full; // [RULE7] [RULE9]

	// tag requests in full modes follow the address match alone
	always_comb begin
		brk_now = 1'b0;
		if (ctrl_q[`DBT_CTRL_PROCESSOR_BREAK_ENABLE]) begin
			if (ctrl_q[`DBT_CTRL_TAG] & full_mode) begin
				brk_now = watch & eq_a; // [RULE5]
			end else begin
				brk_now = hit;
			end
		end
	end

	// apb phases: one wait state, more while the head entry is stale, answer marked by pready
	assign access  = psel & penable;
	assign done    = access & acc_done_q;
	assign pready  = access & acc_done_q;
	assign mapped  = sel_reg(paddr, `DBT_OFF_CMPA) | sel_reg(paddr, `DBT_OFF_CMPB) |
	                 sel_reg(paddr, `DBT_OFF_CTRL) | sel_reg(paddr, `DBT_OFF_STAT) |
	                 sel_reg(paddr, `DBT_OFF_FIFO);
	assign pslverr = pready & ~mapped;
	assign prdata  = rdata_q;
	assign wr_cmpa = done & pwrite & sel_reg(paddr, `DBT_OFF_CMPA);
	assign wr_cmpb = done & pwrite & sel_reg(paddr, `DBT_OFF_CMPB);
	assign wr_ctrl = done & pwrite & sel_reg(paddr, `DBT_OFF_CTRL);
	assign arm     = wr_ctrl & pwdata[`DBT_CTRL_ARM];
	assign pop     = done & ~pwrite & sel_reg(paddr, `DBT_OFF_FIFO) & pop_ok_q;

	// read data selection
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (sel_reg(paddr, `DBT_OFF_CMPA)) begin
			rd_mux[`DBT_ADDR_W-1:0] = cmpa_q;
		end else if (sel_reg(paddr, `DBT_OFF_CMPB)) begin
			rd_mux[`DBT_ADDR_W-1:0] = cmpb_q;
		end else if (sel_reg(paddr, `DBT_OFF_CTRL)) begin
			rd_mux[`DBT_CTRL_W-1:0] = ctrl_q;
			rd_mux[`DBT_CTRL_ARM]   = 1'b0;
		end else if (sel_reg(paddr, `DBT_OFF_STAT)) begin
			rd_mux[`DBT_STAT_RUN]   = run_q;
			rd_mux[`DBT_STAT_AHIT]  = a_seen_q;
			rd_mux[`DBT_STAT_TRIG]  = trig_seen_q;
			rd_mux[`DBT_STAT_FULL]  = fifo_full;
			rd_mux[`DBT_STAT_CN_HI:`DBT_STAT_CN_LO] = cnt_q;
		end else if (sel_reg(paddr, `DBT_OFF_FIFO)) begin
			if (cnt_q != '0) begin
				rd_mux[`DBT_DATA_W-1:0] = head_data;
			end
		end
	end

	// wait-state flag; held off while the head entry is being refreshed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_done_q <= 1'b0;
		end else begin
			acc_done_q <= access & ~acc_done_q & ~head_stale_q;
		end
	end

	// read data captured in each access cycle before pready; a fifo read pops only what it returned,
	// so a push landing after an empty read cannot be dropped unseen
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_q  <= 32'h0000_0000;
			pop_ok_q <= 1'b0;
		end else if (access & ~acc_done_q) begin
			rdata_q  <= pwrite ? 32'h0000_0000 : rd_mux;
			pop_ok_q <= ~pwrite & (cnt_q != '0);
		end
	end

	// comparator value registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmpa_q <= `DBT_CMP_RST;
			cmpb_q <= `DBT_CMP_RST;
		end else begin
			if (wr_cmpa) begin
				cmpa_q <= pwdata[`DBT_ADDR_W-1:0];
			end
			if (wr_cmpb) begin
				cmpb_q <= pwdata[`DBT_ADDR_W-1:0];
			end
		end
	end

	// control register; the arm bit is a command and is not stored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `DBT_CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_q <= pwdata[`DBT_CTRL_W-1:0];
			ctrl_q[`DBT_CTRL_ARM] <= 1'b0;
		end
	end

	// debug run: started by arm, stopped by a trigger outside the store modes, a full fifo in store modes or a control write without arm
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_q <= 1'b0;
		end else if (wr_ctrl) begin
			run_q <= pwdata[`DBT_CTRL_ARM];
		end else if (store_mode & fifo_full) begin
			run_q <= 1'b0; // [RULE8]
		end else if (hit & ~store_mode) begin
			run_q <= 1'b0;
		end
	end

	// remembered comparator a match for the sequential modes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			a_seen_q <= 1'b0;
		end else if (arm) begin
			a_seen_q <= 1'b0; // [RULE12]
		end else if (watch & seq_mode & eq_a) begin
			a_seen_q <= 1'b1; // [RULE3] [RULE9]
		end
	end

	// sticky trigger-seen status, cleared by arming unless a hit comes in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trig_seen_q <= 1'b0;
		end else if (hit) begin
			trig_seen_q <= 1'b1;
		end else if (arm) begin
			trig_seen_q <= 1'b0;
		end
	end

	// fifo pointers and fill count; arming empties the fifo
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			cnt_q    <= '0;
		end else if (arm) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			cnt_q    <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + 1'b1;
			end
			if (push & ~pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (pop & ~push) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end

	// head data lags a pointer move or a write to the head by one cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			head_stale_q <= 1'b0;
		end else begin
			head_stale_q <= (push & (wr_ptr_q == rd_ptr_q)) | pop | arm;
		end
	end

	// registered event outputs toward the core
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trig_q <= 1'b0;
			brk_q  <= 1'b0;
			tag_q  <= 1'b0;
		end else begin
			trig_q <= hit;
			brk_q  <= brk_now;
			tag_q  <= brk_now & ctrl_q[`DBT_CTRL_TAG];
		end
	end

	assign trigger_pulse = trig_q;
	assign break_request = brk_q;
	assign break_is_tag  = tag_q;
	assign run_active    = run_q;

endmodule
`default_nettype wire
